//--- design/monitor_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 125 MHz block clock.
// Notes: Definitions only.
`ifndef MONITOR_CFG_SVH
`define MONITOR_CFG_SVH
// Clock and timing
`define CLK_MHZ 125
`define MS_CYC (1000 * `CLK_MHZ)
`define WDOG_MIN_MS 1000
`define WDOG_CYC (`WDOG_MIN_MS * `MS_CYC)
// Check interval per duty-cycle code, in milliseconds
`define CHK_MS_2 13
`define CHK_MS_3 130
`define CHK_MS_4 500
`define CHK_MS_5 130
`define CHK_MS_6 500
`define CHK_MS_7 2000
// Register offsets
`define ADDR_CFG_FIRST 8'h00
`define ADDR_DISCHARGE 8'h04
`define ADDR_LIMITS 8'h08
`define ADDR_COMMAND 8'h0C
`define ADDR_STATUS 8'h10
// Field positions
`define CF_GPIO_LSB 3
`define CF_WDOG_BIT 7
`define LIM_OV_LSB 8
`define CMD_START_BIT 0
// Reset values
`define DUTY_RST 3'h0
`define GPIO_RST 2'h3
`define DIS_RST 12'h000
`define LIM_RST 8'h00
`endif

//--- design/monitor_pkg.sv
// Purpose: Types shared by the monitor control block.
// Assumes: Constants live in monitor_cfg.svh.
// Notes: Types only.
package monitor_pkg;
  typedef enum logic [1:0] {
    M_STANDBY,
    M_IDLE,
    M_CONVERT,
    M_CHECK
  } mode_t;

  // Software configuration, restored to defaults by the watchdog
  typedef struct packed {
    logic [2:0] duty;
    logic [1:0] gpio;
    logic [7:0] uv;
    logic [7:0] ov;
    logic [11:0] dis;
  } cfg_t;

  // Pins from outside the clock domain
  typedef struct packed {
    logic [3:0] strap;
    logic [1:0] gp;
    logic wd;
    logic csn;
    logic sck;
  } pins_t;

  // Whole state of the block
  typedef struct packed {
    pins_t sy1;
    pins_t sy2;
    logic sck_d;
    logic csn_d;
    logic [7:0] bits;
    mode_t state;
    cfg_t cfg;
    logic [3:0] addr;
    logic [31:0] wd_cnt;
    logic [31:0] chk_cnt;
    logic alert;
    logic fault;
    logic conv_start;
    logic conv_abort;
    logic check_req;
    logic measure_en;
    logic sdo_oe;
    logic [1:0] gp_oe;
    logic [31:0] rdata;
  } st_t;
endpackage

//--- design/monitor_mode_watchdog_gpio.sv
// Purpose: Mode control, command watchdog, open-drain pins and strapping
//          of a multi-cell battery monitor.
// Assumes: Register port on clk_in; serial pins and straps are async.
// Notes: Frame decoding is elsewhere; only frame completion is seen here.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "monitor_cfg.svh"

// Function
// - Alert after watchdog interval without command
// - Alert restores configuration defaults
// - Alert pin is open-drain, pulls low
// - Pin bit zero drives pin low
// - Pin bit one releases pin
// - Pin bit reads actual pin level
// - Bus address from four straps
// - Power-up enters standby
// - Standby disables all but interface, pins and discharge
// - Duty field zero selects standby
// - Standby aborts running conversions
// - Duty one to seven means measure
// - Duty one waits for start command
// - Duty two to seven checks limits
// - Check interval set by duty field
// - Discharge outputs only as host writes
// - Serial data output is open-drain
// - Watchdog idle only at duty zero
// - Alert held until next valid command
// - External low is reported, not timeout
module monitor_mode_watchdog_gpio
  import monitor_pkg::*;
#(
  parameter int unsigned WDOG_CYC = `WDOG_CYC,
  parameter int unsigned MS_CYC = `MS_CYC
) (
  input wire logic clk_in, // Block clock, 125 MHz
  input wire logic rst_b_in, // Synchronous reset, low active
  input wire logic [7:0] addr_in, // Register address
  input wire logic [31:0] wdata_in, // Register write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  input wire logic serial_clock_in, // Serial clock pin
  input wire logic chip_select_in_n, // Chip select pin, low active
  output logic serial_data_out, // Serial data drive level
  output logic serial_data_oe_out, // Serial data pull-down enable
  input wire logic watchdog_alert_n_in, // Alert line level
  output logic watchdog_alert_n_out, // Alert drive level
  output logic watchdog_alert_n_oe_out, // Alert pull-down enable
  input wire logic general_pin_one_in, // Pin one level
  output logic general_pin_one_out, // Pin one drive level
  output logic general_pin_one_oe_out, // Pin one pull-down enable
  input wire logic general_pin_two_in, // Pin two level
  output logic general_pin_two_out, // Pin two drive level
  output logic general_pin_two_oe_out, // Pin two pull-down enable
  input wire logic addr_strap_0, // Address strap bit 0
  input wire logic addr_strap_1, // Address strap bit 1
  input wire logic addr_strap_2, // Address strap bit 2
  input wire logic addr_strap_3, // Address strap bit 3
  output logic [3:0] bus_addr_out, // Strapped serial address
  input wire logic [11:0] cell_under_in, // Per-cell below-limit result
  input wire logic [11:0] cell_over_in, // Per-cell above-limit result
  input wire logic conv_done_in, // Conversion finished pulse
  output logic conv_start_out, // Start conversion pulse
  output logic conv_abort_out, // Abort conversion pulse
  output logic check_req_out, // Limit check pulse
  output logic measure_en_out, // Analog front end enable
  output logic [7:0] undervoltage_limit_out, // Lower cell limit
  output logic [7:0] overvoltage_limit_out, // Upper cell limit
  output logic [11:0] discharge_out // Cell discharge switches
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  st_t st_reg;
  st_t st_next;
  pins_t pins_raw;

  // Power-up configuration, also the watchdog target
  localparam cfg_t CFG_RST = '{
    duty: `DUTY_RST,
    gpio: `GPIO_RST,
    uv: `LIM_RST,
    ov: `LIM_RST,
    dis: `DIS_RST
  };

  // Interval between limit checks for a duty code
  // Counters are 32 bits: the longest interval, 2 s at 125 MHz, needs
  // 250 million cycles and still fits. Codes 0 and 1 never use the
  // result; the default also serves code 7.
  function automatic logic [31:0] chk_cycles(input logic [2:0] duty);
    int unsigned ms;
    ms = 0;
    case (duty)
      3'h2: ms = `CHK_MS_2;
      3'h3: ms = `CHK_MS_3;
      3'h4: ms = `CHK_MS_4;
      3'h5: ms = `CHK_MS_5;
      3'h6: ms = `CHK_MS_6;
      default: ms = `CHK_MS_7;
    endcase
    return 32'(ms * MS_CYC);
  endfunction

  // Gather the asynchronous pins for the synchroniser
  assign pins_raw = '{
    strap: {addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0},
    gp: {general_pin_two_in, general_pin_one_in},
    wd: watchdog_alert_n_in,
    csn: chip_select_in_n,
    sck: serial_clock_in
  };

  //--------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------
  // All pin decisions use the second synchroniser stage or later
  always_comb begin
    logic frame_end;
    logic frame_ok;
    logic wr_hit;
    logic start_cmd;
    logic valid_cmd;
    logic sck_rise;
    logic watch_on;
    frame_end = 1'b0;
    frame_ok = 1'b0;
    wr_hit = 1'b0;
    start_cmd = 1'b0;
    valid_cmd = 1'b0;
    sck_rise = 1'b0;
    watch_on = 1'b0;
    st_next = st_reg;

    // Two-stage synchroniser, then edge history
    // Only the second stage feeds logic; the first may be metastable
    st_next.sy1 = pins_raw;
    st_next.sy2 = st_reg.sy1;
    st_next.sck_d = st_reg.sy2.sck;
    st_next.csn_d = st_reg.sy2.csn;
    st_next.conv_start = 1'b0;
    st_next.conv_abort = 1'b0;
    st_next.check_req = 1'b0;
    st_next.rdata = 32'h0000_0000;

    // Count clock edges inside a frame; low select opens it
    sck_rise = st_reg.sy2.sck && !st_reg.sck_d;
    if (!st_reg.sy2.csn && st_reg.csn_d) begin
      st_next.bits = 8'h00;
    end else if (!st_reg.sy2.csn && sck_rise) begin
      st_next.bits = st_reg.bits + 8'h01;
    end
    // Limitation: only the bit count of a frame is judged here; whether
    // its contents are a valid command is left to the frame decoder.
    // A frame of whole bytes counts as a valid command
    frame_end = st_reg.sy2.csn && !st_reg.csn_d;
    if (frame_end) begin
      frame_ok = (st_reg.bits != 8'h00) && (st_reg.bits[2:0] == 3'h0);
      st_next.bits = 8'h00;
    end

    // Register writes; unmapped offsets are ignored
    if (wr_in) begin
      if (addr_in == `ADDR_CFG_FIRST) begin
        wr_hit = 1'b1;
        st_next.cfg.duty = wdata_in[2:0];
        st_next.cfg.gpio = wdata_in[`CF_GPIO_LSB +: 2];
      end else if (addr_in == `ADDR_DISCHARGE) begin
        wr_hit = 1'b1;
        st_next.cfg.dis = wdata_in[11:0];
      end else if (addr_in == `ADDR_LIMITS) begin
        wr_hit = 1'b1;
        st_next.cfg.uv = wdata_in[7:0];
        st_next.cfg.ov = wdata_in[`LIM_OV_LSB +: 8];
      end else if (addr_in == `ADDR_COMMAND) begin
        wr_hit = 1'b1;
        start_cmd = wdata_in[`CMD_START_BIT];
      end else if (addr_in == `ADDR_STATUS) begin
        wr_hit = 1'b1;
      end
    end
    valid_cmd = wr_hit || frame_ok;

    // Watchdog: idle at duty zero, restarted by each command
    // The timeout sits at the short end of the allowed window, so a host
    // that speaks less than once a period always sees the alert. A write
    // in the same cycle as the timeout wins: the host was in time.
    watch_on = st_reg.cfg.duty != 3'h0;
    if (valid_cmd) begin
      st_next.wd_cnt = 32'h0000_0000;
      st_next.alert = 1'b0;
    end else if (!watch_on) begin
      st_next.wd_cnt = 32'h0000_0000;
    end else if (st_reg.wd_cnt >= WDOG_CYC - 1) begin
      // Timeout drops to standby and turns discharge off
      st_next.alert = 1'b1;
      st_next.cfg = CFG_RST;
      st_next.wd_cnt = 32'h0000_0000;
    end else begin
      st_next.wd_cnt = st_reg.wd_cnt + 32'h0000_0001;
    end

    // Operating mode sequence
    case (st_reg.state)
      M_STANDBY: begin
        if (st_next.cfg.duty != 3'h0) begin
          st_next.state = M_IDLE;
        end
      end
      M_IDLE: begin
        if (start_cmd) begin
          // Start accepted in any measure mode
          st_next.conv_start = 1'b1;
          st_next.state = M_CONVERT;
        end else if (st_reg.cfg.duty >= 3'h2) begin
          // Periodic checks only from code two upward
          if (st_reg.chk_cnt >= chk_cycles(st_reg.cfg.duty) - 1) begin
            st_next.chk_cnt = 32'h0000_0000;
            st_next.check_req = 1'b1;
            st_next.state = M_CHECK;
          end else begin
            st_next.chk_cnt = st_reg.chk_cnt + 32'h0000_0001;
          end
        end else begin
          st_next.chk_cnt = 32'h0000_0000;
        end
      end
      M_CONVERT: begin
        // Conversions refresh the limit flags as well
        if (conv_done_in) begin
          st_next.fault = |(cell_under_in | cell_over_in);
          st_next.state = M_IDLE;
        end
      end
      M_CHECK: begin
        // Comparator results stand with the request pulse
        // This cycle opens the next interval, which keeps the period at
        // exactly the programmed count
        st_next.chk_cnt = 32'h0000_0001;
        st_next.fault = |(cell_under_in | cell_over_in);
        st_next.state = M_IDLE;
      end
      default: begin
        st_next.state = M_STANDBY;
      end
    endcase

    // Duty zero wins over everything: standby, abort a conversion
    // Fault is cleared so that a later measure mode starts clean; the
    // limit result then waits for the next check.
    if (st_next.cfg.duty == 3'h0) begin
      if (st_reg.state == M_CONVERT) begin
        st_next.conv_abort = 1'b1;
      end
      st_next.conv_start = 1'b0;
      st_next.check_req = 1'b0;
      st_next.chk_cnt = 32'h0000_0000;
      st_next.fault = 1'b0;
      st_next.state = M_STANDBY;
    end
    st_next.measure_en = st_next.state != M_STANDBY;

    // Data pin pulls low in a frame while busy, or out of limits at duty two or above
    // Outside a frame the pin is released by the third clock edge after select rises,
    // so other parties on the wired line are not held low past that by this block.
    st_next.sdo_oe = !st_reg.sy2.csn &&
      ((st_reg.state == M_CONVERT) ||
       (st_reg.cfg.duty >= 3'h2 && st_reg.fault));

    // General pins: a zero bit enables the pull-down
    st_next.gp_oe = ~st_next.cfg.gpio;

    // Register reads; pins and alert line read as they stand
    // Pin bits read the synchronised level, so a new drive setting shows
    // up a few cycles later, never at once.
    if (rd_in) begin
      if (addr_in == `ADDR_CFG_FIRST) begin
        st_next.rdata[2:0] = st_reg.cfg.duty;
        st_next.rdata[`CF_GPIO_LSB +: 2] = st_reg.sy2.gp;
        st_next.rdata[`CF_WDOG_BIT] = st_reg.sy2.wd;
      end else if (addr_in == `ADDR_DISCHARGE) begin
        st_next.rdata[11:0] = st_reg.cfg.dis;
      end else if (addr_in == `ADDR_LIMITS) begin
        st_next.rdata[7:0] = st_reg.cfg.uv;
        st_next.rdata[`LIM_OV_LSB +: 8] = st_reg.cfg.ov;
      end else if (addr_in == `ADDR_STATUS) begin
        st_next.rdata[0] = st_reg.measure_en;
        st_next.rdata[1] = st_reg.state == M_CONVERT;
        st_next.rdata[2] = !st_reg.fault;
        st_next.rdata[3] = st_reg.alert;
        st_next.rdata[7:4] = st_reg.addr;
      end
    end
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  // Straps are caught from the synchronised pins while reset is held,
  // so the address is stable from the first edge after release.
  // Edge history resets to high levels: no false edge follows.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
      st_reg.sy1 <= pins_raw;
      st_reg.sy2 <= st_reg.sy1;
      st_reg.sck_d <= 1'b1;
      st_reg.csn_d <= 1'b1;
      st_reg.state <= M_STANDBY;
      st_reg.cfg <= CFG_RST;
      st_reg.gp_oe <= ~`GPIO_RST;
      st_reg.addr <= st_reg.sy2.strap;
    end else begin
      st_reg <= st_next;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  // Open-drain pins only ever drive low; the enable does the work
  // A constant low level means no pin can ever source current
  assign rdata_out = st_reg.rdata;
  assign serial_data_out = 1'b0;
  assign serial_data_oe_out = st_reg.sdo_oe;
  assign watchdog_alert_n_out = 1'b0;
  assign watchdog_alert_n_oe_out = st_reg.alert;
  assign general_pin_one_out = 1'b0;
  assign general_pin_one_oe_out = st_reg.gp_oe[0];
  assign general_pin_two_out = 1'b0;
  assign general_pin_two_oe_out = st_reg.gp_oe[1];
  assign bus_addr_out = st_reg.addr;
  assign conv_start_out = st_reg.conv_start;
  assign conv_abort_out = st_reg.conv_abort;
  assign check_req_out = st_reg.check_req;
  assign measure_en_out = st_reg.measure_en;
  assign undervoltage_limit_out = st_reg.cfg.uv;
  assign overvoltage_limit_out = st_reg.cfg.ov;
  assign discharge_out = st_reg.cfg.dis;

endmodule

//--- bench/host_link_model.sv
// Purpose: Host end of the serial link, chip select and link clock.
// Assumes: 160 ns link clock, free in phase against the block clock.
// Notes: Clock stands low between frames; data line not modelled.
`timescale 1ns/1ps
module host_link_model (
  output logic serial_clock_out, // Link clock to the block
  output logic chip_select_out_n // Chip select, low active
);
  // ----
  // Frame generator
  // ----
  // Deselected and quiet at rest
  initial begin
    serial_clock_out = 1'b0;
    chip_select_out_n = 1'b1;
  end
  // Counts that are no multiple of eight give a frame to be rejected
  task automatic frame(input int n);
    #37 chip_select_out_n = 1'b0;
    repeat (n) begin
      #80 serial_clock_out = 1'b1;
      #80 serial_clock_out = 1'b0;
    end
    #43 chip_select_out_n = 1'b1;
  endtask
endmodule

//--- bench/monitor_assertions.sv
// Purpose: Port checks of the monitor control block.
// Assumes: Sees top ports only; frames are not decoded.
// Notes: Bound to the block after the module.
`timescale 1ns/1ps
module monitor_assertions
  import monitor_pkg::*;
#(
  parameter int unsigned WDOG_CYC = 200
) (
  input wire logic clk_in, // Clock
  input wire logic rst_b_in, // Reset
  input wire logic [7:0] addr_in, // Address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic chip_select_in_n, // Chip select
  input wire logic serial_data_out, // Data level
  input wire logic serial_data_oe_out, // Data enable
  input wire logic watchdog_alert_n_out, // Alert level
  input wire logic watchdog_alert_n_oe_out, // Alert enable
  input wire logic general_pin_one_oe_out, // Pin one enable
  input wire logic general_pin_two_oe_out, // Pin two enable
  input wire logic conv_start_out, // Start pulse
  input wire logic conv_abort_out, // Abort pulse
  input wire logic check_req_out, // Check pulse
  input wire logic measure_en_out, // Measure enable
  input wire logic [7:0] undervoltage_limit_out, // Lower limit
  input wire logic [11:0] discharge_out, // Discharge
  input wire logic [3:0] bus_addr_out // Strapped address
);
  // ----
  // Helper counters
  // ----
  // Frames are unseen here, so idle time is over-counted; unmapped writes up to 8'h10 still restart it
  logic [31:0] idle_reg;
  logic [2:0] cs_hi_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || (wr_in && addr_in <= 8'h10)) begin
      idle_reg <= 32'h0;
    end else if (idle_reg != 32'hFFFFFFFF) begin
      idle_reg <= idle_reg + 32'h1;
    end
    if (!rst_b_in || !chip_select_in_n) begin
      cs_hi_reg <= 3'h0;
    end else if (cs_hi_reg != 3'h7) begin
      cs_hi_reg <= cs_hi_reg + 3'h1;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_drain_only:
    assert property (!watchdog_alert_n_out && !serial_data_out)
    else $error("open-drain output drives high");
  a_pin_low:
    assert property (wr_in && addr_in == 8'h00 && !wdata_in[3]
      |-> ##[1:2] general_pin_one_oe_out)
    else $error("pin one not pulled low");
  a_pin_free:
    assert property (wr_in && addr_in == 8'h00 && wdata_in[4]
      |-> ##[1:2] !general_pin_two_oe_out)
    else $error("pin two not released");
  a_mode_sel:
    assert property (wr_in && addr_in == 8'h00
      |=> measure_en_out == ($past(wdata_in[2:0]) != 3'h0))
    else $error("mode does not follow duty field");
  a_abort_stby:
    assert property (conv_abort_out |-> !measure_en_out ##1 !conv_abort_out)
    else $error("abort outside standby");
  a_start_refused:
    assert property (wr_in && addr_in == 8'h0C && !measure_en_out
      |=> !conv_start_out)
    else $error("start in standby");
  a_check_mode:
    assert property (check_req_out |-> measure_en_out ##1 !check_req_out)
    else $error("limit check out of measure mode");
  a_wdog_time:
    assert property ($rose(watchdog_alert_n_oe_out)
      |-> idle_reg >= WDOG_CYC - 2)
    else $error("alert too early");
  a_alert_clear:
    assert property (watchdog_alert_n_oe_out && wr_in && addr_in <= 8'h10
      |=> !watchdog_alert_n_oe_out)
    else $error("alert kept after command");
  a_alert_hold:
    assert property (watchdog_alert_n_oe_out && !wr_in && cs_hi_reg == 3'h7
      |=> watchdog_alert_n_oe_out)
    else $error("alert dropped without command");
  a_cfg_default:
    assert property ($rose(watchdog_alert_n_oe_out) && !wr_in ##1 !wr_in[*2]
      |-> discharge_out == 12'h000 && undervoltage_limit_out == 8'h00
      && !measure_en_out && !general_pin_one_oe_out)
    else $error("configuration not back to defaults");
  a_sdo_idle:
    assert property (cs_hi_reg == 3'h7 |-> !serial_data_oe_out)
    else $error("data line pulled while deselected");
  a_strap_hold:
    assert property ($stable(bus_addr_out))
    else $error("address moved after reset");
  c_alert: cover property ($rose(watchdog_alert_n_oe_out));
  c_start: cover property (conv_start_out);
  c_abort: cover property (conv_abort_out);
  c_check: cover property (check_req_out);
endmodule
bind monitor_mode_watchdog_gpio monitor_assertions #(
  .WDOG_CYC(WDOG_CYC)
) port_chk (
  .clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .chip_select_in_n,
  .serial_data_out, .serial_data_oe_out, .watchdog_alert_n_out,
  .watchdog_alert_n_oe_out, .general_pin_one_oe_out,
  .general_pin_two_oe_out, .conv_start_out, .conv_abort_out,
  .check_req_out, .measure_en_out, .undervoltage_limit_out,
  .discharge_out, .bus_addr_out
);

//--- bench/testbench.sv
// Purpose: Self-checking bench of the monitor control block.
// Assumes: Shortened watchdog and millisecond counts.
// Notes: Pull-ups on the alert and general pin lines are modelled here.
`timescale 1ns/1ps
module testbench;
  localparam int WD = 3000; // Watchdog cycles, kept short
  localparam int MS = 10; // Cycles per millisecond, kept short
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] strap = 4'hA;
  logic [11:0] cell_under_in = 12'h000;
  logic [11:0] cell_over_in = 12'h000;
  logic conv_done_in = 1'b0;
  logic wd_ext = 1'b1;
  logic gp_ext = 1'b1;
  logic [31:0] rdata_out, r;
  logic serial_clock_in, chip_select_in_n, serial_data_out;
  logic serial_data_oe_out, watchdog_alert_n_out, watchdog_alert_n_oe_out;
  logic general_pin_one_out, general_pin_one_oe_out;
  logic general_pin_two_out, general_pin_two_oe_out;
  logic conv_start_out, conv_abort_out, check_req_out, measure_en_out;
  logic [3:0] bus_addr_out;
  logic [7:0] undervoltage_limit_out, overvoltage_limit_out;
  logic [11:0] discharge_out;
  logic [2:0] dtab [3] = '{3'h2, 3'h3, 3'h5};
  int mtab [3] = '{13, 130, 130};
  int n_errors = 0;
  int n_checks = 0;
  int n;
  // Open-drain lines sit high unless some party pulls them low
  wire watchdog_alert_n_in = !watchdog_alert_n_oe_out && wd_ext;
  wire general_pin_one_in = !general_pin_one_oe_out && gp_ext;
  wire general_pin_two_in = !general_pin_two_oe_out;
  host_link_model host (
    .serial_clock_out(serial_clock_in),
    .chip_select_out_n(chip_select_in_n)
  );
  monitor_mode_watchdog_gpio #(
    .WDOG_CYC(WD),
    .MS_CYC(MS)
  ) dut (
    .clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .serial_clock_in, .chip_select_in_n, .serial_data_out,
    .serial_data_oe_out, .watchdog_alert_n_in, .watchdog_alert_n_out,
    .watchdog_alert_n_oe_out, .general_pin_one_in, .general_pin_one_out,
    .general_pin_one_oe_out, .general_pin_two_in, .general_pin_two_out,
    .general_pin_two_oe_out, .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
    .addr_strap_3(strap[3]), .bus_addr_out, .cell_under_in, .cell_over_in,
    .conv_done_in, .conv_start_out, .conv_abort_out, .check_req_out,
    .measure_en_out, .undervoltage_limit_out, .overvoltage_limit_out,
    .discharge_out
  );
  // ----
  // Clock and tasks
  // ----
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    q = rdata_out;
  endtask
  // Bounded wait for the alert or for a check pulse
  task automatic wait_for(input bit al, input int lim, output int k);
    k = 0;
    while ((al ? watchdog_alert_n_oe_out : check_req_out) !== 1'b1) begin
      cyc(1);
      k++;
      if (k > lim) begin
        n_errors++;
        $display("wrong value wait expected 1 seen 0");
        test_done();
      end
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    cyc(1);
    chk("strap", 32'hA, {28'h0, bus_addr_out});
    rd(8'h10, r);
    chk("status", 32'hA4, r);
    wr(8'h00, 32'h00);
    cyc(6);
    chk("pin_oe", 32'h3,
      {general_pin_two_oe_out, general_pin_one_oe_out});
    rd(8'h00, r);
    chk("pin_rb", 32'h80, r);
    gp_ext <= 1'b0;
    wd_ext <= 1'b0;
    wr(8'h00, 32'h18);
    cyc(6);
    rd(8'h00, r);
    chk("pin_in", 32'h10, r);
    cyc(WD + 100);
    chk("no_alert", 32'h0, watchdog_alert_n_oe_out);
    wd_ext <= 1'b1;
    gp_ext <= 1'b1;
    wr(8'h04, 32'h5A5);
    wr(8'h08, 32'h3C2A);
    wr(8'h0C, 32'h1);
    chk("start_sb", 32'h0, conv_start_out);
    cyc(1);
    chk("dis", 32'h5A5, discharge_out);
    chk("lim", 32'h3C2A,
      {overvoltage_limit_out, undervoltage_limit_out});
    wr(8'h00, 32'h19);
    chk("meas", 32'h1, measure_en_out);
    n = 0;
    repeat (200) begin
      cyc(1);
      if (check_req_out !== 1'b0) n++;
    end
    chk("no_check", 32'h0, n);
    wr(8'h0C, 32'h1);
    chk("start", 32'h1, conv_start_out);
    rd(8'h10, r);
    chk("conv", 32'hA7, r);
    @(posedge clk_in);
    conv_done_in <= 1'b1;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    rd(8'h10, r);
    chk("done", 32'hA5, r);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h18);
    chk("abort", 32'h1, conv_abort_out);
    chk("stby", 32'h0, measure_en_out);
    foreach (dtab[i]) begin
      wr(8'h00, {29'h3, dtab[i]});
      wait_for(1'b0, WD, n);
      cyc(1);
      wait_for(1'b0, WD, n);
      chk("interval", mtab[i] * MS, n + 1);
    end
    wr(8'h00, 32'h1A);
    @(posedge clk_in);
    cell_under_in <= 12'h001;
    wait_for(1'b0, WD, n);
    cyc(2);
    rd(8'h10, r);
    chk("fault", 32'hA1, r);
    fork
      host.frame(8);
      begin
        cyc(30);
        chk("sdo", 32'h1, serial_data_oe_out);
      end
    join
    @(posedge clk_in);
    cell_under_in <= 12'h000;
    wr(8'h04, 32'hFFF);
    wr(8'h00, 32'h01);
    cyc(2000);
    wr(8'h08, 32'h1111);
    wait_for(1'b1, WD + 10, n);
    chk("wd_time", 32'h1, n >= WD - 2 && n <= WD + 3);
    cyc(3);
    chk("dflt", 32'h0,
      {discharge_out, overvoltage_limit_out, undervoltage_limit_out,
      measure_en_out, general_pin_one_oe_out});
    rd(8'h00, r);
    chk("line", 32'h18, r);
    host.frame(5);
    cyc(40);
    chk("held", 32'h1, watchdog_alert_n_oe_out);
    wr(8'h00, 32'h18);
    chk("clear", 32'h0, watchdog_alert_n_oe_out);
    test_done();
  end
endmodule
